// ### acs_pkg.sv
package acs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFFSET         = 8'h00;
    localparam logic [7:0]  SETUP_OFFSET        = 8'h04;
    localparam logic [7:0]  DATA_OFFSET         = 8'h14;
    localparam logic [7:0]  CAL_OFFSET          = 8'h18;
    localparam logic [31:0] SETUP_RESET         = 32'h0000000C;
    localparam logic [31:0] SETUP_WRITE_MASK    = 32'h00540BFE;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          CHAN_LSB            = 1;
    localparam int          BIAS_LSB            = 4;
    localparam int          OSR_LSB             = 6;
    localparam int          ATTEN_LSB           = 8;
    localparam int          REPEAT_BIT          = 11;
    localparam int          BYPASS_BIT          = 18;
    localparam int          PDM_RATE_BIT        = 20;
    localparam int          MIC_OUT_BIT         = 22;
    localparam int          HALT_BIT            = 4;
    localparam logic [2:0]  CHAN_RESET          = 3'h6;

    // ------------------------------------------------------------
    // Microphone clock timing
    // ------------------------------------------------------------
    localparam int          REF_CLK_KHZ         = 25000;
    localparam int          PDM_FAST_KHZ        = 1600;
    localparam int          PDM_SLOW_KHZ        = 800;
    localparam logic [4:0]  PDM_FAST_HALF       =
        5'(REF_CLK_KHZ / (2 * PDM_FAST_KHZ));
    localparam logic [4:0]  PDM_SLOW_HALF       =
        5'(REF_CLK_KHZ / (2 * PDM_SLOW_KHZ));

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CHAN_OPEN     = 3'b000,
        CHAN_SE_TWO   = 3'b001,
        CHAN_SE_ONE   = 3'b010,
        CHAN_DIFF     = 3'b011,
        CHAN_THERMAL  = 3'b100,
        CHAN_BATTERY  = 3'b101,
        CHAN_SHORT    = 3'b110,
        CHAN_UNUSED   = 3'b111
    } acs_chan_type;

    typedef struct packed {
        logic [3:0] pos_sel;   // bias, in1, ref06, none
        logic [3:0] neg_sel;   // bias, in2, thermal, battery
        logic       neg_ref06;
    } acs_switch_type;

    typedef struct packed {
        logic [1:0] bias_level;
        logic [7:0] osr_value;
        logic [1:0] atten;
        logic       repeat_mode;
        logic       bypass;
    } acs_front_type;

endpackage

// ### acs_pdm_clock.sv
`timescale 1ns/1ps
`default_nettype none
module acs_pdm_clock (
    input  wire logic ref_clk,   // System clock
    input  wire logic rst_n,     // Synchronised reset
    input  wire logic enable,    // Drive clock out
    input  wire logic slow,      // Select slow rate
    output var  logic pdm_clock_pin,   // Clock level
    output var  logic pdm_oe     // Pin enable
);
    logic [4:0] count;
    logic [4:0] half;

    assign half = slow ? acs_pkg::PDM_SLOW_HALF : acs_pkg::PDM_FAST_HALF;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= 5'h00;
            pdm_clock_pin <= 1'b0;
        end else if (!enable) begin
            count   <= 5'h00;
            pdm_clock_pin <= 1'b0;
        end else if (count >= half - 5'h01) begin
            count   <= 5'h00;
            pdm_clock_pin <= ~pdm_clock_pin;
        end else begin
            count   <= count + 5'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pdm_oe <= 1'b0;
        end else begin
            pdm_oe <= enable;
        end
    end
endmodule
`default_nettype wire

// ### acs_setup.sv
`timescale 1ns/1ps
`default_nettype none
module acs_setup (
    input  wire logic                    ref_clk,      // 25 MHz clock
    input  wire logic                    resetn,       // Async reset
    input  wire logic                    reg_sel,      // Access strobe
    input  wire logic                    reg_write,    // Write, else read
    input  wire logic [7:0]              reg_addr,     // Byte offset
    input  wire logic [31:0]             reg_wdata,    // Write data
    output var  logic [31:0]             reg_rdata,    // Read data
    input  wire logic                    conv_valid,   // Result strobe
    input  wire logic [15:0]             conv_value,   // Two's complement
    input  wire logic                    cal_valid,    // Calibration strobe
    input  wire logic [15:0]             cal_value,    // Calibration result
    output var  acs_pkg::acs_switch_type switches,     // Input switch set
    output var  acs_pkg::acs_front_type  front,        // Front-end setup
    output var  logic                    halt_pulse,   // Stop and power down
    output var  logic                    pdm_clock_pin_out,  // Microphone clock
    output var  logic                    pdm_clock_pin_oe    // Pin drive enable
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic        rst_meta;
    logic        rst_n;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    logic [31:0] setup;
    logic [31:0] result;
    logic [31:0] cal_word;
    logic        wr_setup;
    logic        wr_ctrl;

    assign wr_setup = reg_sel && reg_write
                      && (reg_addr == acs_pkg::SETUP_OFFSET);
    assign wr_ctrl  = reg_sel && reg_write
                      && (reg_addr == acs_pkg::CTRL_OFFSET);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup <= acs_pkg::SETUP_RESET;
        end else if (wr_setup) begin
            setup <= reg_wdata & acs_pkg::SETUP_WRITE_MASK;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_pulse <= 1'b0;
        end else begin
            halt_pulse <= wr_ctrl && reg_wdata[acs_pkg::HALT_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= 32'h00000000;
        end else if (conv_valid) begin
            result <= setup[acs_pkg::BYPASS_BIT]
                      ? {16'h0000, conv_value}
                      : {conv_value, 16'h0000};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_word <= 32'h00000000;
        end else if (cal_valid) begin
            cal_word <= setup[acs_pkg::BYPASS_BIT]
                        ? {16'h0000, cal_value}
                        : {cal_value, 16'h0000};
        end
    end

    // Halt bit never reads back, so control reads zero here
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_sel && !reg_write) begin
            case (reg_addr)
                acs_pkg::SETUP_OFFSET: reg_rdata <= setup;
                acs_pkg::DATA_OFFSET:  reg_rdata <= result;
                acs_pkg::CAL_OFFSET:   reg_rdata <= cal_word;
                default:               reg_rdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Input switch decode
    // ------------------------------------------------------------
    function automatic acs_pkg::acs_switch_type decode_chan(
        input logic [2:0] code
    );
        acs_pkg::acs_switch_type s;
        s = '0;
        case (acs_pkg::acs_chan_type'(code))
            acs_pkg::CHAN_OPEN:    s = '0;
            acs_pkg::CHAN_SE_TWO: begin
                s.pos_sel = 4'b1000;
                s.neg_sel = 4'b0100;
            end
            acs_pkg::CHAN_SE_ONE: begin
                s.pos_sel = 4'b0100;
                s.neg_sel = 4'b1000;
            end
            acs_pkg::CHAN_DIFF: begin
                s.pos_sel = 4'b0100;
                s.neg_sel = 4'b0100;
            end
            acs_pkg::CHAN_THERMAL: begin
                s.pos_sel = 4'b0010;
                s.neg_sel = 4'b0010;
            end
            acs_pkg::CHAN_BATTERY: begin
                s.pos_sel = 4'b0010;
                s.neg_sel = 4'b0001;
            end
            acs_pkg::CHAN_SHORT: begin
                s.pos_sel   = 4'b0010;
                s.neg_ref06 = 1'b1;
            end
            // Undefined code kept safe with switches open
            default:               s = '0;
        endcase
        return s;
    endfunction

    function automatic logic [7:0] osr_of(input logic [1:0] code);
        logic [7:0] v;
        v = 8'hC8;
        case (code)
            2'h0:    v = 8'hC8;
            2'h1:    v = 8'h64;
            2'h2:    v = 8'h40;
            2'h3:    v = 8'h20;
            default: v = 8'hC8;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Front-end outputs
    // ------------------------------------------------------------
    // channel decode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Short code: both inputs held on the 0.6 V node
            switches <= '{pos_sel: 4'h2, neg_sel: 4'h0, neg_ref06: 1'h1};
        end else begin
            switches <= decode_chan(setup[acs_pkg::CHAN_LSB +: 3]);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            front <= '{2'h0, 8'hC8, 2'h0, 1'b0, 1'b0};
        end else begin
            front.bias_level  <= setup[acs_pkg::BIAS_LSB +: 2];
            front.osr_value   <= osr_of(setup[acs_pkg::OSR_LSB +: 2]);
            front.atten       <= setup[acs_pkg::ATTEN_LSB +: 2];
            front.repeat_mode <= setup[acs_pkg::REPEAT_BIT];
            front.bypass      <= setup[acs_pkg::BYPASS_BIT];
        end
    end

    // ------------------------------------------------------------
    // Microphone clock
    // ------------------------------------------------------------
    // clock pin gated
    acs_pdm_clock u_pdm (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .enable  (setup[acs_pkg::MIC_OUT_BIT]),
        .slow    (setup[acs_pkg::PDM_RATE_BIT]),
        .pdm_clock_pin (pdm_clock_pin_out),
        .pdm_oe  (pdm_clock_pin_oe)
    );
endmodule
`default_nettype wire

// ### acs_setup_properties.sv
`timescale 1ns/1ps
`default_nettype none
module acs_setup_properties (
    input  wire logic                    ref_clk,     // System clock
    input  wire logic                    resetn,      // Async reset
    input  wire logic                    reg_sel,     // Access strobe
    input  wire logic                    reg_write,   // Write, else read
    input  wire logic [7:0]              reg_addr,    // Byte offset
    input  wire logic [31:0]             reg_wdata,   // Write data
    input  wire logic [31:0]             reg_rdata,   // Read data
    input  wire acs_pkg::acs_switch_type switches,    // Input switches
    input  wire acs_pkg::acs_front_type  front,       // Front-end setup
    input  wire logic                    halt_pulse,  // Halt strobe
    input  wire logic                    pdm_clock_pin_out, // Microphone clock
    input  wire logic                    pdm_clock_pin_oe   // Pin enable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic wr_set;
    logic wr_ctl;
    logic rd_dead;
    assign wr_set = reg_sel && reg_write && reg_addr == acs_pkg::SETUP_OFFSET;
    assign wr_ctl = reg_sel && reg_write && reg_addr == acs_pkg::CTRL_OFFSET;
    // Reads that have no stored value behind them
    assign rd_dead = reg_sel && !reg_write && !(reg_addr inside
        {acs_pkg::SETUP_OFFSET, acs_pkg::DATA_OFFSET, acs_pkg::CAL_OFFSET});
    chk_halt_pulse: assert property (
        wr_ctl && reg_wdata[4] |=> halt_pulse) else $error("halt missing");
    chk_halt_cause: assert property (
        halt_pulse |-> $past(wr_ctl && reg_wdata[4]))
        else $error("halt without write");
    chk_repeat_mode: assert property (
        wr_set |-> ##2 front.repeat_mode == $past(reg_wdata[11], 2))
        else $error("repeat mode wrong");
    chk_bypass_bit: assert property (
        wr_set |-> ##2 front.bypass == $past(reg_wdata[18], 2))
        else $error("bypass wrong");
    chk_osr_value: assert property (
        wr_set |-> ##2 front.osr_value == ($past(reg_wdata[7:6], 2) == 2'h0
        ? 8'hC8 : $past(reg_wdata[7:6], 2) == 2'h1 ? 8'h64
        : $past(reg_wdata[7:6], 2) == 2'h2 ? 8'h40 : 8'h20))
        else $error("ratio wrong");
    chk_bias_atten: assert property (
        wr_set |-> ##2 {front.bias_level, front.atten} ==
        {$past(reg_wdata[5:4], 2), $past(reg_wdata[9:8], 2)})
        else $error("bias or attenuator wrong");
    chk_chan_open: assert property (
        wr_set && reg_wdata[3:1] == 3'h0 |-> ##2 switches == 9'h000)
        else $error("switches not open");
    chk_chan_diff: assert property (
        wr_set && reg_wdata[3:1] == 3'h3 |-> ##2 switches == 9'h088)
        else $error("differential routing wrong");
    chk_dead_reads: assert property (
        rd_dead |=> reg_rdata == 32'h0) else $error("read not zero");
    chk_pdm_driven: assert property (
        $rose(pdm_clock_pin_out) |-> pdm_clock_pin_oe) else $error("clock undriven");
endmodule
`default_nettype wire

// ### acs_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module acs_front_model (
    input  wire logic        ref_clk,    // System clock
    input  wire logic        start,      // Deliver one result
    input  wire logic        cal,        // Calibration, else sample
    input  wire logic [15:0] level,      // Value to deliver
    output var  logic        conv_valid, // Sample strobe
    output var  logic [15:0] conv_value, // Sample value
    output var  logic        cal_valid,  // Calibration strobe
    output var  logic [15:0] cal_value   // Calibration value
);
    initial begin
        conv_valid = 1'b0;
        cal_valid = 1'b0;
        conv_value = 16'h0000;
        cal_value = 16'h0000;
    end
    // signed samples
    // Idle values flip so a stale word never looks valid
    always @(posedge ref_clk) begin
        conv_valid <= start && !cal;
        cal_valid <= start && cal;
        conv_value <= (start && !cal) ? level : ~conv_value;
        cal_value <= (start && cal) ? level : ~cal_value;
    end
endmodule
`default_nettype wire

// ### tb_acs_setup.sv
`timescale 1ns/1ps
`default_nettype none
module tb_acs_setup;
    logic                    ref_clk = 1'b0;
    logic                    resetn = 1'b0;
    logic                    reg_sel = 1'b0;
    logic                    reg_write = 1'b0;
    logic [7:0]              reg_addr = 8'h00;
    logic [31:0]             reg_wdata = 32'h0;
    logic                    start = 1'b0;
    logic                    cal = 1'b0;
    logic [15:0]             level = 16'h0000;
    logic [31:0]             reg_rdata, w;
    logic                    conv_valid, cal_valid, halt_pulse;
    logic [15:0]             conv_value, cal_value;
    logic                    pdm_clock_pin_out, pdm_clock_pin_oe;
    acs_pkg::acs_switch_type switches;
    acs_pkg::acs_front_type  front;
    logic [31:0]             exp_q[$];
    logic [8:0]              sw_tab[8] = '{9'h000, 9'h108, 9'h090, 9'h088,
                                           9'h044, 9'h042, 9'h041, 9'h000};
    logic [7:0]              osr_tab[4] = '{8'hC8, 8'h64, 8'h40, 8'h20};
    int                      n_mismatch = 0;
    int                      compares = 0;
    int                      i;
    time                     t0;
    always #20 ref_clk = ~ref_clk;
    acs_setup acs_setup_inst (.ref_clk, .resetn, .reg_sel, .reg_write,
        .reg_addr, .reg_wdata, .reg_rdata, .conv_valid, .conv_value,
        .cal_valid, .cal_value, .switches, .front, .halt_pulse,
        .pdm_clock_pin_out, .pdm_clock_pin_oe);
    acs_front_model acs_front_model_inst (.ref_clk, .start, .cal, .level,
        .conv_valid, .conv_value, .cal_valid, .cal_value);
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t read %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_port(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t port %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        {reg_sel, reg_write, reg_addr, reg_wdata} = {2'b11, a, d};
        @(negedge ref_clk);
        reg_sel = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(negedge ref_clk);
        {reg_sel, reg_write, reg_addr} = {2'b10, a};
        @(negedge ref_clk);
        reg_sel = 1'b0;
    endtask
    task automatic res(input logic c, input logic [15:0] v);
        @(negedge ref_clk);
        {start, cal, level} = {1'b1, c, v};
        @(negedge ref_clk);
        start = 1'b0;
    endtask
    task automatic stop_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Read data settles one cycle after the strobe
    always @(posedge ref_clk) begin
        if (reg_sel === 1'b1 && reg_write === 1'b0) begin
            @(negedge ref_clk);
            cmp_word(reg_rdata, exp_q.pop_front());
        end
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        stop_test();
    end
    initial begin
        w = $urandom(65419);
        repeat (6) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (3) @(negedge ref_clk);
        cmp_port(32'(switches), 32'h041);
        rd(acs_pkg::SETUP_OFFSET, acs_pkg::SETUP_RESET);
        for (i = 0; i < 8; i++) begin
            wr(acs_pkg::SETUP_OFFSET, 32'(i << 1) | 32'h20);
            repeat (2) @(negedge ref_clk);
            cmp_port(32'(switches), 32'(sw_tab[i]));
        end
        for (i = 0; i < 8; i++) begin
            w = $urandom();
            wr(acs_pkg::SETUP_OFFSET, w);
            rd(acs_pkg::SETUP_OFFSET, w & acs_pkg::SETUP_WRITE_MASK);
            cmp_port(32'(front), 32'({w[5:4], osr_tab[w[7:6]], w[9:8], w[11],
                w[18]}));
        end
        for (i = 0; i < 2; i++) begin
            wr(acs_pkg::SETUP_OFFSET, 32'h20 | (32'(i) << 18));
            w = $urandom();
            res(1'b1, w[15:0]);
            res(1'b0, w[31:16]);
            rd(acs_pkg::CAL_OFFSET,
                i ? {16'h0, w[15:0]} : {w[15:0], 16'h0});
            rd(acs_pkg::DATA_OFFSET, i ? w >> 16 : w & 32'hFFFF0000);
        end
        for (i = 0; i < 2; i++) begin
            w = $urandom();
            wr(acs_pkg::SETUP_OFFSET, 32'h820 | (32'(i) << 18));
            repeat (i ? 3 : 10) res(1'b0, w[31:16]);
            res(1'b0, w[15:0]);
            rd(acs_pkg::DATA_OFFSET,
                i ? {16'h0, w[15:0]} : {w[15:0], 16'h0});
        end
        for (i = 0; i < 2; i++) begin
            wr(acs_pkg::SETUP_OFFSET, 32'h00400000 | (32'(i) << 20));
            repeat (2) @(posedge pdm_clock_pin_out);
            t0 = $time;
            @(posedge pdm_clock_pin_out);
            w = 32'(2 * (i ? acs_pkg::PDM_SLOW_HALF : acs_pkg::PDM_FAST_HALF));
            cmp_port(32'(($time - t0) / 40), w);
        end
        wr(acs_pkg::SETUP_OFFSET, 32'h0);
        repeat (3) @(negedge ref_clk);
        cmp_port({30'h0, pdm_clock_pin_oe, pdm_clock_pin_out}, 32'h0);
        wr(acs_pkg::CTRL_OFFSET, 32'h10);
        cmp_port(32'(halt_pulse), 32'h1);
        rd(acs_pkg::CTRL_OFFSET, 32'h0);
        cmp_port(32'(halt_pulse), 32'h0);
        rd(8'h40, 32'h0);
        repeat (3) @(negedge ref_clk);
        stop_test();
    end
endmodule
bind acs_setup acs_setup_properties acs_setup_properties_inst (.ref_clk,
    .resetn, .reg_sel, .reg_write, .reg_addr, .reg_wdata, .reg_rdata,
    .switches, .front, .halt_pulse, .pdm_clock_pin_out, .pdm_clock_pin_oe);
`default_nettype wire
